// ---- coupler_ctrl.sv ----
// Programming, status, card detect and card line control of a smartcard coupler
`timescale 1ns/100ps
`include "coupler_defs.svh"

module coupler_ctrl
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic chip_select_n,
    input wire logic power_on_request,
    input wire logic ready_mode_line_in,
    output logic ready_mode_line_out,
    output logic ready_mode_line_oe,
    output logic wakeup_int_n,
    input wire logic host_reset_in,
    input wire logic host_serial_in,
    output logic host_serial_out,
    output logic host_serial_oe,
    input wire logic host_aux8_line_in,
    output logic host_aux8_line_out,
    output logic host_aux8_line_oe,
    input wire logic card_serial_line_in,
    output logic card_serial_line_out,
    output logic card_serial_line_oe,
    input wire logic card_aux8_line_in,
    output logic card_aux8_line_out,
    output logic card_aux8_line_oe,
    output logic card_reset_out,
    input wire logic sync_clock_in,
    input wire logic async_clock_in,
    output logic card_clock_out,
    input wire logic card_detect_switch,
    input wire logic detect_polarity_select,
    input wire logic battery_ok,
    input wire logic supply_in_range,
    input wire logic converter_ok,
    output logic converter_enable,
    output coupler_pkg::config_type card_config,
    output coupler_pkg::card_enables_type card_enables,
    output coupler_pkg::mode_type op_mode
);
    import coupler_pkg::*;

    // =====================================================
    // Input synchronisers and edge detection
    logic [1:0] cs_sync_reg, cs_sync_next;
    logic [1:0] pwr_sync_reg, pwr_sync_next;
    logic cs_prev_reg, cs_prev_next;
    logic pwr_prev_reg, pwr_prev_next;
    logic cs_n, pwr, cs_rise, cs_fall, pwr_rise, pwr_fall;

    always_comb
    begin
        cs_sync_next = {cs_sync_reg[0], chip_select_n};
        pwr_sync_next = {pwr_sync_reg[0], power_on_request};
        cs_prev_next = cs_sync_reg[1];
        pwr_prev_next = pwr_sync_reg[1];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cs_sync_reg <= 2'h3;
            pwr_sync_reg <= 2'h0;
            cs_prev_reg <= 1'b1;
            pwr_prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            cs_sync_reg <= cs_sync_next;
            pwr_sync_reg <= pwr_sync_next;
            cs_prev_reg <= cs_prev_next;
            pwr_prev_reg <= pwr_prev_next;
        end
    end

    assign cs_n = cs_sync_reg[1];
    assign pwr = pwr_sync_reg[1];
    assign cs_rise = cs_n && !cs_prev_reg;
    assign cs_fall = !cs_n && cs_prev_reg;
    assign pwr_rise = pwr && !pwr_prev_reg;
    assign pwr_fall = !pwr && pwr_prev_reg;

    // =====================================================
    // Card detect debounce and wake-up
    logic presence_raw;
    logic presence_reg, presence_next;
    logic [10:0] deb_cnt_reg, deb_cnt_next;
    logic int_n_reg, int_n_next;

    assign presence_raw = detect_polarity_select ? !card_detect_switch : card_detect_switch;

    always_comb
    begin
        presence_next = presence_reg;
        deb_cnt_next = 11'h000;
        int_n_next = int_n_reg;
        if (cs_rise || pwr_rise)
            int_n_next = 1'b1;
        if (presence_raw != presence_reg)
        begin
            deb_cnt_next = deb_cnt_reg + 11'h001;
            if (deb_cnt_reg == 11'(`DEBOUNCE_CYCLES - 1))
            begin
                presence_next = presence_raw;
                deb_cnt_next = 11'h000;
                int_n_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            presence_reg <= 1'b0;
            deb_cnt_reg <= 11'h000;
            int_n_reg <= 1'b1;
        end
        else if (clk_en && battery_ok)
        begin
            presence_reg <= presence_next;
            deb_cnt_reg <= deb_cnt_next;
            int_n_reg <= int_n_next;
        end
    end

    assign wakeup_int_n = int_n_reg;

    // =====================================================
    // Modes, configuration capture and power sequencer
    mode_type mode_reg, mode_next;
    config_type cfg_reg, cfg_next;
    logic [2:0] step_reg, step_next;
    logic [4:0] tick_reg, tick_next;
    logic serial_hold_reg, serial_hold_next;
    logic aux_hold_reg, aux_hold_next;
    logic rst_hold_reg, rst_hold_next;
    logic powered;

    function automatic logic [1:0] decode_clock(input logic rst_lvl, input logic io_lvl);
        decode_clock = {rst_lvl, io_lvl};
    endfunction

    assign powered = (mode_reg == MODE_TRANSACTION) || (mode_reg == MODE_IDLE);

    always_comb
    begin
        mode_next = mode_reg;
        cfg_next = cfg_reg;
        step_next = step_reg;
        tick_next = tick_reg;
        serial_hold_next = serial_hold_reg;
        aux_hold_next = aux_hold_reg;
        rst_hold_next = rst_hold_reg;
        if (!cs_n && !host_serial_oe)
            serial_hold_next = host_serial_in;
        if (!cs_n && !host_aux8_line_oe)
            aux_hold_next = host_aux8_line_in;
        if (!cs_n)
            rst_hold_next = host_reset_in;
        unique case (mode_reg)
            MODE_STANDBY:
                if (cs_fall)
                    mode_next = ready_mode_line_in ? MODE_ACTIVE : MODE_PROGRAM;
            MODE_PROGRAM:
                if (cs_rise)
                begin
                    cfg_next.supply_5v = pwr;
                    cfg_next.clock_sel = decode_clock(host_reset_in, host_serial_in);
                    mode_next = MODE_STANDBY;
                end
            MODE_ACTIVE:
                if (cs_rise)
                    mode_next = MODE_STANDBY;
                else if (pwr_rise && presence_reg)
                begin
                    mode_next = MODE_TRANSACTION;
                    tick_next = 5'h00;
                end
            MODE_TRANSACTION, MODE_IDLE:
            begin
                if (cs_rise)
                    mode_next = MODE_IDLE;
                else if (cs_fall)
                    mode_next = MODE_TRANSACTION;
                if ((pwr_fall && !cs_n) || !presence_reg || !converter_ok)
                    mode_next = MODE_ACTIVE;
            end
            default:
                mode_next = MODE_STANDBY;
        endcase
        // Step through the card lines one at a time while the battery is good, up in powered modes and down otherwise
        if (tick_reg != 5'(`SEQ_STEP_CYCLES - 1))
            tick_next = tick_reg + 5'h01;
        else
        begin
            tick_next = 5'h00;
            if (powered && step_reg != `SEQ_LAST_STEP && (step_reg != 3'h0 || supply_in_range))
                step_next = step_reg + 3'h1;
            else if (!powered && step_reg != 3'h0)
                step_next = step_reg - 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_reg <= MODE_STANDBY;
            cfg_reg <= '{supply_5v: `CFG_RESET_SUPPLY_5V, clock_sel: `CFG_RESET_CLOCK_SEL};
            step_reg <= 3'h0;
            tick_reg <= 5'h00;
            serial_hold_reg <= 1'b1;
            aux_hold_reg <= 1'b1;
            rst_hold_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!battery_ok)
            begin
                mode_reg <= MODE_STANDBY;
                step_reg <= 3'h0;
            end
            else
            begin
                mode_reg <= mode_next;
                cfg_reg <= cfg_next;
                step_reg <= step_next;
            end
            tick_reg <= tick_next;
            serial_hold_reg <= serial_hold_next;
            aux_hold_reg <= aux_hold_next;
            rst_hold_reg <= rst_hold_next;
        end
    end

    assign op_mode = mode_reg;
    assign card_config = cfg_reg;
    assign converter_enable = powered;
    assign card_enables.supply_en = step_reg != 3'h0;
    assign card_enables.serial_en = step_reg >= 3'h2;
    assign card_enables.clock_en = step_reg >= 3'h3;
    assign card_enables.aux_en = step_reg >= 3'h4;
    assign card_enables.reset_en = step_reg >= 3'h5;

    // =====================================================
    // Status on the ready/mode line
    assign ready_mode_line_oe = !cs_n && (mode_reg == MODE_ACTIVE || powered);
    assign ready_mode_line_out = pwr ? (converter_ok && supply_in_range) : presence_reg;

    // =====================================================
    // Line translation; a host line that the device itself pulls low is never read back into the hold
    logic serial_lines_up, aux_lines_up;
    assign serial_lines_up = card_enables.serial_en && mode_reg == MODE_TRANSACTION;
    assign aux_lines_up = card_enables.aux_en && mode_reg == MODE_TRANSACTION;
    assign card_serial_line_out = serial_hold_reg;
    assign card_serial_line_oe = card_enables.serial_en && !serial_hold_reg;
    assign host_serial_out = card_serial_line_in;
    assign host_serial_oe = serial_lines_up && !card_serial_line_in && serial_hold_reg && !cs_n;
    assign card_aux8_line_out = aux_hold_reg;
    assign card_aux8_line_oe = card_enables.aux_en && !aux_hold_reg;
    assign host_aux8_line_out = card_aux8_line_in;
    assign host_aux8_line_oe = aux_lines_up && !card_aux8_line_in && aux_hold_reg && !cs_n;
    assign card_reset_out = card_enables.reset_en && rst_hold_reg;

    // =====================================================
    // Glitch-free card clock selection
    // A gate that moves only while source and output are low keeps every card clock phase whole
    logic [1:0] div_reg, div_next;
    logic clk_out_reg, clk_out_next, gate_reg, gate_next, async_prev_reg, async_prev_next;
    logic [1:0] active_sel_reg, active_sel_next;
    logic src_level;

    always_comb
    begin
        async_prev_next = async_clock_in;
        div_next = (async_clock_in && !async_prev_reg) ? div_reg + 2'h1 : div_reg;
        unique case (active_sel_reg)
            `CLKSEL_SYNC: src_level = sync_clock_in;
            `CLKSEL_DIV4: src_level = div_reg[1];
            `CLKSEL_DIV2: src_level = div_reg[0];
            `CLKSEL_DIV1: src_level = async_clock_in;
        endcase
        active_sel_next = active_sel_reg;
        clk_out_next = gate_reg && src_level;
        gate_next = (clk_out_reg || src_level) ? gate_reg : (card_enables.clock_en && active_sel_reg == cfg_reg.clock_sel);
        if (active_sel_reg != cfg_reg.clock_sel && !clk_out_reg && !src_level)
        begin
            active_sel_next = cfg_reg.clock_sel;
            clk_out_next = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_reg <= 2'h0;
            clk_out_reg <= 1'b0;
            active_sel_reg <= `CFG_RESET_CLOCK_SEL;
            gate_reg <= 1'b0;
            async_prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            div_reg <= div_next;
            clk_out_reg <= clk_out_next;
            active_sel_reg <= active_sel_next;
            gate_reg <= gate_next;
            async_prev_reg <= async_prev_next;
        end
    end

    assign card_clock_out = clk_out_reg;

endmodule

// ---- coupler_ctrl_assertions.sv ----
// Port-level concurrent checks for the coupler control block
`timescale 1ns/100ps
`include "coupler_defs.svh"
module coupler_ctrl_checker
(
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic power_on_request,
    input wire logic ready_mode_line_in,
    input wire logic ready_mode_line_out,
    input wire logic ready_mode_line_oe,
    input wire logic wakeup_int_n,
    input wire logic host_reset_in,
    input wire logic host_serial_in,
    input wire logic battery_ok,
    input wire logic supply_in_range,
    input wire logic converter_ok,
    input coupler_pkg::config_type card_config,
    input coupler_pkg::mode_type op_mode
);
    import coupler_pkg::*;
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    property p_reset_state;
        $fell(rst) |-> card_config == {`CFG_RESET_SUPPLY_5V, `CFG_RESET_CLOCK_SEL}
            && op_mode == MODE_STANDBY && wakeup_int_n;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state after reset wrong");
    // Three samples cover the two-flop synchroniser lag
    property p_status_released;
        chip_select_n[*3] |-> !ready_mode_line_oe;
    endproperty
    a_status_released: assert property (p_status_released) else $error("status driven while deselected");
    property p_status_power;
        power_on_request[*3] ##0 ready_mode_line_oe |-> ready_mode_line_out == (converter_ok && supply_in_range);
    endproperty
    a_status_power: assert property (p_status_power) else $error("converter status wrong");
    property p_cfg_when_program;
        $changed(card_config) |-> $past(op_mode) == MODE_PROGRAM;
    endproperty
    a_cfg_when_program: assert property (p_cfg_when_program) else $error("config changed outside programming");
    property p_cfg_values;
        $changed(card_config) |-> card_config == {$past(power_on_request), $past(host_reset_in), $past(host_serial_in)};
    endproperty
    a_cfg_values: assert property (p_cfg_values) else $error("captured option levels wrong");
    property p_program_entry;
        op_mode == MODE_PROGRAM && $past(op_mode) != MODE_PROGRAM |-> !$past(ready_mode_line_in);
    endproperty
    a_program_entry: assert property (p_program_entry) else $error("programming entered with mode line high");
    property p_battery;
        (!battery_ok)[*2] |-> op_mode == MODE_STANDBY;
    endproperty
    a_battery: assert property (p_battery) else $error("operation while battery low");
    property p_wake_clear;
        $rose(wakeup_int_n) |-> (chip_select_n && !$past(chip_select_n, 6))
            || (power_on_request && !$past(power_on_request, 6));
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake-up cleared without a rising edge");
endmodule

bind coupler_ctrl coupler_ctrl_checker u_checker (.clk(clk), .rst(rst), .chip_select_n(chip_select_n),
    .power_on_request(power_on_request), .ready_mode_line_in(ready_mode_line_in),
    .ready_mode_line_out(ready_mode_line_out), .ready_mode_line_oe(ready_mode_line_oe),
    .wakeup_int_n(wakeup_int_n), .host_reset_in(host_reset_in), .host_serial_in(host_serial_in),
    .battery_ok(battery_ok), .supply_in_range(supply_in_range), .converter_ok(converter_ok),
    .card_config(card_config), .op_mode(op_mode));

// ---- coupler_ctrl_tb_top.sv ----
// Self-checking bench for the coupler control block
`timescale 1ns/100ps
`include "coupler_defs.svh"
module coupler_ctrl_tb_top;
    import coupler_pkg::*;
    typedef struct packed {logic [2:0] opts; logic [2:0] cfg;} row_type;
    row_type rows [8] = '{'{3'h0, {1'b0, `CLKSEL_SYNC}}, '{3'h1, {1'b0, `CLKSEL_DIV4}}, '{3'h3, {1'b0, `CLKSEL_DIV2}},
        '{3'h2, {1'b0, `CLKSEL_DIV1}}, '{3'h4, {1'b1, `CLKSEL_SYNC}}, '{3'h5, {1'b1, `CLKSEL_DIV4}},
        '{3'h7, {1'b1, `CLKSEL_DIV2}}, '{3'h6, {1'b1, `CLKSEL_DIV1}}};
    logic clk, rst, det, pol, batt, sup, conv, async_clk, card_io, last_cclk;
    logic rdy_out, rdy_oe, int_n, hs_out, hs_oe, ha_out, ha_oe, cs_out, cs_oe, ca_out, ca_oe, cclk, conv_en, crst;
    config_type cfg;
    card_enables_type ens;
    mode_type mode;
    int errors = 0, n_compared = 0, cycles = 0, run = 3, edges = 0, k;
    wire cs_n, pwr, mode_low, h_reset, h_serial;
    // Open-drain lines resolve to the pull-up level unless someone pulls low
    coupler_ctrl DUT (.clk(clk), .rst(rst), .clk_en(1'b1), .chip_select_n(cs_n), .power_on_request(pwr),
        .ready_mode_line_in(!mode_low && (!rdy_oe || rdy_out)), .ready_mode_line_out(rdy_out),
        .ready_mode_line_oe(rdy_oe),
        .wakeup_int_n(int_n), .host_reset_in(h_reset), .host_serial_in(h_serial & !(hs_oe & !hs_out)),
        .host_serial_out(hs_out), .host_serial_oe(hs_oe), .host_aux8_line_in(!(ha_oe & !ha_out)),
        .host_aux8_line_out(ha_out), .host_aux8_line_oe(ha_oe), .card_serial_line_in(card_io & !(cs_oe & !cs_out)),
        .card_serial_line_out(cs_out), .card_serial_line_oe(cs_oe), .card_aux8_line_in(card_io & !(ca_oe & !ca_out)),
        .card_aux8_line_out(ca_out), .card_aux8_line_oe(ca_oe), .card_reset_out(crst), .sync_clock_in(1'b0),
        .async_clock_in(async_clk), .card_clock_out(cclk), .card_detect_switch(det), .detect_polarity_select(pol),
        .battery_ok(batt), .supply_in_range(sup), .converter_ok(conv), .converter_enable(conv_en),
        .card_config(cfg), .card_enables(ens), .op_mode(mode));
    coupler_host_model host (.clk(clk), .cs_n(cs_n), .pwr(pwr), .mode_low(mode_low), .reset_line(h_reset),
        .serial_line(h_serial));
    task automatic check(input logic [4:0] got, input logic [4:0] exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task automatic close_out;
    begin
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always
    begin
        repeat (3) @(negedge clk);
        async_clk = ~async_clk;
    end
    // Whole run needs about 3400 cycles; the ceiling leaves generous slack
    always @(negedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            $display("ERROR %0t run did not finish", $time);
            close_out();
        end
        if (rst)
            run = 3;
        else if (cclk !== last_cclk)
        begin
            check(run >= 3, 1'b1);
            edges++;
            run = 0;
        end
        run++;
        last_cclk = cclk;
    end
    initial
    begin
        rst = 1'b1;
        {det, pol, batt, sup, conv, async_clk, card_io, last_cclk} = 8'h3A;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(cfg, {`CFG_RESET_SUPPLY_5V, `CFG_RESET_CLOCK_SEL});
        check({mode, int_n, rdy_oe}, {MODE_STANDBY, 2'b10});
        foreach (rows[i])
        begin
            host.program_state(rows[i].opts);
            check(cfg, rows[i].cfg);
        end
        det = 1'b1;
        repeat (1010) @(negedge clk);
        check(int_n, 1'b0);
        host.set_lines(1'b0, 1'b0, 1'b1);
        repeat (6) @(negedge clk);
        check({mode, rdy_oe, rdy_out}, {MODE_ACTIVE, 2'b11});
        host.set_lines(1'b1, 1'b0, 1'b1);
        repeat (6) @(negedge clk);
        check({int_n, rdy_oe}, 2'b10);
        pol = 1'b1;
        repeat (1010) @(negedge clk);
        host.set_lines(1'b0, 1'b0, 1'b1);
        repeat (6) @(negedge clk);
        check({int_n, rdy_oe, rdy_out}, 3'h2);
        pol = 1'b0;
        repeat (1010) @(negedge clk);
        host.set_lines(1'b0, 1'b1, 1'b1);
        for (k = 0; k < 400 && ens !== 5'h1F; k++)
            @(negedge clk);
        check({mode, int_n, conv_en}, {MODE_TRANSACTION, 2'b11});
        check({ens}, 5'h1F);
        check(crst, 1'b1);
        check(rdy_out, 1'b1);
        card_io = 1'b0;
        @(negedge clk);
        check({hs_oe, hs_out, ha_oe, ha_out, cs_oe}, 5'h14);
        card_io = 1'b1;
        host.set_lines(1'b0, 1'b1, 1'b0);
        repeat (4) @(negedge clk);
        check({cs_oe, cs_out, ca_oe}, 3'h4);
        host.set_lines(1'b1, 1'b1, 1'b0);
        repeat (6) @(negedge clk);
        host.set_lines(1'b1, 1'b1, 1'b1);
        repeat (6) @(negedge clk);
        check({mode, cs_oe, cs_out}, {MODE_IDLE, 2'b10});
        check(edges > 10, 1'b1);
        host.set_lines(1'b0, 1'b1, 1'b1);
        repeat (6) @(negedge clk);
        conv = 1'b0;
        #1;
        check({rdy_oe, rdy_out}, 2'b10);
        @(negedge clk);
        batt = 1'b0;
        repeat (3) @(negedge clk);
        check({mode, conv_en}, {MODE_STANDBY, 1'b0});
        batt = 1'b1;
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check({cfg, int_n}, {`CFG_RESET_SUPPLY_5V, `CFG_RESET_CLOCK_SEL, 1'b1});
        close_out();
    end
endmodule

// ---- coupler_defs.svh ----
// Timing counts, configuration encodings and reset values of the coupler control block
`ifndef COUPLER_DEFS_SVH
`define COUPLER_DEFS_SVH

`define CLK_FREQ_HZ 20000000
`define DEBOUNCE_TIME_NS 50000
`define DEBOUNCE_CYCLES ((`DEBOUNCE_TIME_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define SEQ_STEP_TIME_NS 1000
`define SEQ_STEP_CYCLES ((`SEQ_STEP_TIME_NS * (`CLK_FREQ_HZ / 1000000)) / 1000)
`define CFG_RESET_SUPPLY_5V 1'b1
`define CFG_RESET_CLOCK_SEL 2'h0
`define CLKSEL_SYNC 2'h0
`define CLKSEL_DIV4 2'h1
`define CLKSEL_DIV2 2'h3
`define CLKSEL_DIV1 2'h2
`define SEQ_LAST_STEP 3'h5

`endif

// ---- coupler_host_model.sv ----
// Host controller model driving the coupler control lines
`timescale 1ns/100ps
module coupler_host_model
(
    input wire logic clk,
    output logic cs_n = 1'b1,
    output logic pwr = 1'b0,
    output logic mode_low = 1'b0,
    output logic reset_line = 1'b0,
    output logic serial_line = 1'b1
);
    // A single select line, so only one coupler is ever addressed
    task automatic set_lines(input logic c, input logic p, input logic s);
    begin
        @(negedge clk);
        cs_n = c;
        pwr = p;
        serial_line = s;
    end
    endtask
    // Options are held well past the select rise so a synchronised capture still sees them
    task automatic program_state(input logic [2:0] opts);
    begin
        @(negedge clk);
        mode_low = 1'b1;
        repeat (5) @(negedge clk);
        cs_n = 1'b0;
        repeat (6) @(negedge clk);
        {pwr, reset_line, serial_line} = opts;
        repeat (6) @(negedge clk);
        cs_n = 1'b1;
        repeat (8) @(negedge clk);
        mode_low = 1'b0;
        {pwr, reset_line, serial_line} = 3'h3;
    end
    endtask
endmodule

// ---- coupler_pkg.sv ----
// Types shared by the coupler control block
package coupler_pkg;

    typedef struct packed {
        logic supply_5v;
        logic [1:0] clock_sel;
    } config_type;

    typedef enum logic [2:0] {
        MODE_STANDBY = 3'h0,
        MODE_PROGRAM = 3'h1,
        MODE_ACTIVE = 3'h2,
        MODE_TRANSACTION = 3'h3,
        MODE_IDLE = 3'h4
    } mode_type;

    typedef struct packed {
        logic supply_en;
        logic serial_en;
        logic clock_en;
        logic aux_en;
        logic reset_en;
    } card_enables_type;

endpackage
